// *** core/ept_timer.v ***
// Dual 8-bit / cascaded 16-bit down-counter with event, pulse-width, interrupt and pulse-output functions.
// Function
// - Counter-mode bit 1 clocks timer 0 from external event edges.
// - Event mode: timer 1 normal timer, or cascade forms 16-bit event counter.
// - Event mode ignores the timer 0 prescale ratio field.
// - Polarity 0 counts falling edges, 1 counts rising edges.
// - Noise rejector counts at second falling 2048 Hz edge after level change.
// - Function bit 1 in timer mode gates prescaled clock by input level.
// - Pulse-width mode: timer 1 normal, or cascade forms 16-bit counter.
// - Pulse-width polarity 0 counts during low, 1 during high.
// - Underflow sets the timer's flag; enable bit gates the interrupt.
// - Shared two-bit priority field gives level 0 to 3.
// - Timer 1 vector 000006H, timer 0 vector 000008H.
// - Cascade never sets timer 0 flag; combined underflow sets timer 1 flag.
// - Pulse output toggles per selected timer underflow; select 0 timer 0.
// - Cascade makes pulse output follow combined underflow, ignoring select.
// - Output enable 1 drives toggle and complement; 0 drives high and low.
// - Toggle reaches pulse pin only with its latch 1; inverted latch unused.
// - Output enable gates the toggle unsynchronised; a short glitch is acceptable.
// - Timer 1 underflow is the serial clock, divided by 32 downstream.
// - Timer 1 reload of zero is legal, underflowing every prescaled clock.
// - Mode register bits 4..0 reset to 0; upper three bits read 0.
// - Event mode ignores the prescaler 0 source select.
// - In normal timer mode the polarity bit has no effect.
`timescale 1ns/1ns
`default_nettype none
`include "ept_map.vh"
module ept_timer (
  input  wire        aclk,                    // System clock, 50 MHz.
  input  wire        aresetn,                 // Synchronous reset, active low.
  input  wire        slow_oscillator,         // Slow source clock, sampled level.
  input  wire        fast_oscillator,         // Fast source clock, sampled level.
  input  wire        event_input_pin,         // External event input.
  input  wire [17:0] s_axi_awaddr,            // Write address.
  input  wire        s_axi_awvalid,           // Write address valid.
  output wire        s_axi_awready,           // Write address ready.
  input  wire [31:0] s_axi_wdata,             // Write data.
  input  wire [3:0]  s_axi_wstrb,             // Write strobes.
  input  wire        s_axi_wvalid,            // Write data valid.
  output wire        s_axi_wready,            // Write data ready.
  output wire [1:0]  s_axi_bresp,             // Write response.
  output wire        s_axi_bvalid,            // Write response valid.
  input  wire        s_axi_bready,            // Write response ready.
  input  wire [17:0] s_axi_araddr,            // Read address.
  input  wire        s_axi_arvalid,           // Read address valid.
  output wire        s_axi_arready,           // Read address ready.
  output wire [31:0] s_axi_rdata,             // Read data.
  output wire [1:0]  s_axi_rresp,             // Read response.
  output wire        s_axi_rvalid,            // Read data valid.
  input  wire        s_axi_rready,            // Read data ready.
  output wire        t0_irq,                  // Timer 0 interrupt request.
  output wire        t1_irq,                  // Timer 1 interrupt request.
  output wire [1:0]  timer_irq_priority,      // Priority level of both timers.
  output wire [23:0] t0_irq_vector,           // Timer 0 exception vector.
  output wire [23:0] t1_irq_vector,           // Timer 1 exception vector.
  output wire        serial_clock_tick,       // Timer 1 underflow pulse for the serial unit.
  output wire        t1_reload_count_mode,    // Timer 1 repeat setting, seen by the serial unit.
  output wire        pulse_out_pin,           // Halved underflow output.
  output wire        inverted_pulse_out_pin   // Complement of the halved underflow output.
);

  // Byte address of a register index.
  function [17:0] badr;
    input [15:0] idx;
    begin
      badr = {idx, 2'b00};
    end
  endfunction

  // Prescaler terminal count for a two-bit ratio field: /1, /4, /16, /64.
  function [5:0] ptop;
    input [1:0] sel;
    begin
      case (sel)
        2'b00:   ptop = 6'h00;
        2'b01:   ptop = 6'h03;
        2'b10:   ptop = 6'h0F;
        default: ptop = 6'h3F;
      endcase
    end
  endfunction

  reg  [4:0]  mode_r;
  reg  [7:0]  t0ctl_r;
  reg  [7:0]  t1ctl_r;
  reg  [7:0]  t0rld_r;
  reg  [7:0]  t1rld_r;
  reg  [7:0]  t0cnt_r;
  reg  [7:0]  t1cnt_r;
  reg  [6:0]  irq_r;
  reg         half_uf_r;
  reg  [5:0]  psc0_r;
  reg  [5:0]  psc1_r;
  reg  [2:0]  osc_s0_r;
  reg  [2:0]  osc_s1_r;
  reg         ev_s1_r;
  reg         ev_s2_r;
  reg         ev_d_r;
  reg         nr_lvl_r;
  reg  [1:0]  nr_cnt_r;
  reg  [14:0] nr_div_r;
  reg         nr_clk_r;
  reg         aw_hold_r;
  reg  [17:0] aw_addr_r;
  reg         w_hold_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;
  reg         bvalid_r;
  reg  [1:0]  bresp_r;
  reg         rvalid_r;
  reg  [1:0]  rresp_r;
  reg  [31:0] rdata_r;

  // Reload of the reference divider; it is cut to the divider width where it is used.
  localparam integer NR_TOP = `EPT_NR_HALF - 1;

  wire cascade  = mode_r[`EPT_MODE_CASCADE];
  wire cnt_mode = t0ctl_r[`EPT_C_CNTMODE];
  wire func_sel = t0ctl_r[`EPT_C_FUNC];
  wire pol_sel  = t0ctl_r[`EPT_C_POL];
  wire run0     = t0ctl_r[`EPT_C_PRUN];
  // In cascade the timer 1 run bit is dead; timer 0 controls the pair.
  wire run1     = t1ctl_r[`EPT_C_PRUN] & ~cascade;

  // Sampled oscillator levels; the third stage only feeds the edge detector.
  wire osc0_rise = osc_s0_r[1] & ~osc_s0_r[2];
  wire slow_oscillator_rise = osc_s1_r[1] & ~osc_s1_r[2];
  wire ck1src    = cascade ? mode_r[`EPT_MODE_CK0] : mode_r[`EPT_MODE_CK1];
  wire [1:0] psc1sel = cascade ? t0ctl_r[4:3] : t1ctl_r[4:3];
  wire src0_tick = mode_r[`EPT_MODE_CK0] ? slow_oscillator_rise : osc0_rise;
  wire src1_tick = ck1src ? slow_oscillator_rise : osc0_rise;
  wire pre0_tick = src0_tick & (psc0_r == ptop(t0ctl_r[4:3]));
  wire pre1_tick = src1_tick & (psc1_r == ptop(psc1sel));

  // Event edge, with or without the noise rejector.
  // Both edge sources look at the second synchroniser stage only.
  wire ev_edge_raw = pol_sel ? (ev_s2_r & ~ev_d_r) : (~ev_s2_r & ev_d_r);
  // A falling reference edge is the last cycle of its high half.
  wire nr_fall     = (nr_div_r == 15'd0) & nr_clk_r;
  wire nr_change   = nr_fall & (ev_s2_r != nr_lvl_r) & (nr_cnt_r == 2'd1);
  wire nr_edge     = nr_change & (pol_sel ? ev_s2_r : ~ev_s2_r);
  wire ev_tick     = func_sel ? nr_edge : ev_edge_raw;
  wire pw_gate     = pol_sel ? ev_s2_r : ~ev_s2_r;

  // Timer 0 input: event edges ignore prescaler 0 entirely.
  wire t0_in   = cnt_mode ? ev_tick : (pre0_tick & (~func_sel | pw_gate));
  wire t0_step = run0 & t0_in;
  wire t0_uf   = t0_step & (t0cnt_r == 8'h00);

  // In cascade timer 1 counts only the borrows of timer 0, so the pair is one 16-bit counter.
  wire t1_step = cascade ? t0_uf : (run1 & pre1_tick);
  wire t1_uf   = t1_step & (t1cnt_r == 8'h00);

  // The halved output follows the combined borrow in cascade, whatever the channel select.
  wire sel_uf  = (cascade | mode_r[`EPT_MODE_OUTSEL]) ? t1_uf : t0_uf;

  wire wr_go = aw_hold_r & w_hold_r & ~bvalid_r;
  wire [15:0] wr_idx = aw_addr_r[17:2];
  wire [7:0]  wd = w_data_r[7:0];
  wire        wb = w_strb_r[0];
  wire        wr_hit = (wr_idx >= `EPT_IDX_MODE) && (wr_idx <= `EPT_IDX_IRQ);

  always @(posedge aclk) begin
    if (!aresetn) begin
      mode_r   <= 5'h00;
      t0ctl_r  <= 8'h00;
      t1ctl_r  <= 8'h00;
      t0rld_r  <= `EPT_RLD_RESET;
      t1rld_r  <= `EPT_RLD_RESET;
      t0cnt_r  <= 8'hFF;
      t1cnt_r  <= 8'hFF;
      irq_r    <= 7'h40;
      half_uf_r <= 1'b0;
      psc0_r   <= 6'h00;
      psc1_r   <= 6'h00;
      osc_s0_r <= 3'h0;
      osc_s1_r <= 3'h0;
      ev_s1_r  <= 1'b1;
      ev_s2_r  <= 1'b1;
      ev_d_r   <= 1'b1;
      nr_lvl_r <= 1'b1;
      nr_cnt_r <= 2'd0;
      nr_div_r <= 15'd0;
      nr_clk_r <= 1'b0;
    end else begin
      osc_s0_r <= {osc_s0_r[1:0], slow_oscillator};
      osc_s1_r <= {osc_s1_r[1:0], fast_oscillator};
      ev_s1_r  <= event_input_pin;
      ev_s2_r  <= ev_s1_r;
      ev_d_r   <= ev_s2_r;

      // Internal 2048 Hz reference for the noise rejector.
      // It runs free, so its phase against an input change is arbitrary.
      if (nr_div_r == 15'd0) begin
        nr_div_r <= NR_TOP[14:0];
        nr_clk_r <= ~nr_clk_r;
      end else begin
        nr_div_r <= nr_div_r - 15'd1;
      end
      // A level change restarts the count; the second falling reference edge accepts it.
      if (ev_s2_r == nr_lvl_r) begin
        nr_cnt_r <= 2'd0;
      end else if (nr_fall) begin
        if (nr_cnt_r == 2'd1) begin
          nr_lvl_r <= ev_s2_r;
          nr_cnt_r <= 2'd0;
        end else begin
          nr_cnt_r <= nr_cnt_r + 2'd1;
        end
      end

      // A stopped prescaler restarts from zero, so the first tick after run is a full period.
      if (!run0) begin
        psc0_r <= 6'h00;
      end else if (src0_tick) begin
        psc0_r <= pre0_tick ? 6'h00 : psc0_r + 6'h01;
      end

      if (!run1) begin
        psc1_r <= 6'h00;
      end else if (src1_tick) begin
        psc1_r <= pre1_tick ? 6'h00 : psc1_r + 6'h01;
      end

      // A borrow reloads the counter, which makes a reload of zero borrow on every step.
      if (t0_step) begin
        t0cnt_r <= (t0cnt_r == 8'h00) ? t0rld_r : t0cnt_r - 8'h01;
      end
      if (t1_step) begin
        t1cnt_r <= (t1cnt_r == 8'h00) ? t1rld_r : t1cnt_r - 8'h01;
      end
      // The toggle halves the borrow rate of the chosen timer.
      if (sel_uf) begin
        half_uf_r <= ~half_uf_r;
      end

      // One-shot stops the run bit on underflow.
      if (t0_uf && !t0ctl_r[`EPT_C_CONT] && !cascade) begin
        t0ctl_r[`EPT_C_PRUN] <= 1'b0;
      end
      if (t1_uf && cascade && !t0ctl_r[`EPT_C_CONT]) begin
        t0ctl_r[`EPT_C_PRUN] <= 1'b0;
      end
      if (t1_uf && !cascade && !t1ctl_r[`EPT_C_CONT]) begin
        t1ctl_r[`EPT_C_PRUN] <= 1'b0;
      end

      if (wr_go && wb) begin
        case (wr_idx)
          `EPT_IDX_MODE:  mode_r <= wd[4:0];
          `EPT_IDX_T0CTL: begin
            t0ctl_r <= {wd[7:2], 1'b0, wd[0]};
            if (wd[`EPT_C_PSET]) t0cnt_r <= t0rld_r;
            if (wd[`EPT_C_PSET] && cascade) t1cnt_r <= t1rld_r;
          end
          `EPT_IDX_T1CTL: begin
            t1ctl_r <= {3'b000, wd[4:2], 1'b0, wd[0]};
            if (wd[`EPT_C_PSET] && !cascade) t1cnt_r <= t1rld_r;
          end
          `EPT_IDX_T0RLD: t0rld_r <= wd;
          `EPT_IDX_T1RLD: t1rld_r <= wd;
          `EPT_IDX_IRQ:   irq_r[6:2] <= wd[6:2];
          default: ;
        endcase
      end

      // Flags: write 1 clears, but a same-cycle underflow wins.
      if (wr_go && wb && wr_idx == `EPT_IDX_IRQ) begin
        if (wd[`EPT_I_F0]) irq_r[`EPT_I_F0] <= 1'b0;
        if (wd[`EPT_I_F1]) irq_r[`EPT_I_F1] <= 1'b0;
      end
      // The sets come last so that they override a clear in the same cycle.
      if (t0_uf && !cascade) begin
        irq_r[`EPT_I_F0] <= 1'b1;
      end
      if (t1_uf) begin
        irq_r[`EPT_I_F1] <= 1'b1;
      end
    end
  end

  assign t0_irq = irq_r[`EPT_I_F0] & irq_r[`EPT_I_E0];
  assign t1_irq = irq_r[`EPT_I_F1] & irq_r[`EPT_I_E1];
  assign timer_irq_priority = irq_r[`EPT_I_PRIO_HI:`EPT_I_PRIO_LO];
  assign t0_irq_vector = `EPT_VEC_T0;
  assign t1_irq_vector = `EPT_VEC_T1;
  assign serial_clock_tick = t1_uf;
  assign t1_reload_count_mode = t1ctl_r[`EPT_C_CONT];
  // The enable gates the toggle directly, so switching it may clip one half cycle.
  // With the output enabled and the pin latch at 0 the true pin stays low; the inverted pin has no latch of its own.
  wire out_en = mode_r[`EPT_MODE_OUTEN];
  assign pulse_out_pin          = ~out_en | (half_uf_r & irq_r[`EPT_I_LATCH]);
  assign inverted_pulse_out_pin = out_en & ~half_uf_r;

  // AXI4-Lite slave: address and data held until both present, one write and one read at a time.
  assign s_axi_awready = ~aw_hold_r & ~bvalid_r;
  assign s_axi_wready  = ~w_hold_r & ~bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;

  wire [15:0] rd_idx = s_axi_araddr[17:2];
  reg  [7:0]  rd_val;
  reg         rd_hit;
  always @* begin
    rd_hit = 1'b1;
    case (rd_idx)
      `EPT_IDX_MODE:  rd_val = {3'b000, mode_r};
      `EPT_IDX_T0CTL: rd_val = t0ctl_r;
      `EPT_IDX_T1CTL: rd_val = t1ctl_r;
      `EPT_IDX_T0RLD: rd_val = t0rld_r;
      `EPT_IDX_T1RLD: rd_val = t1rld_r;
      `EPT_IDX_T0CNT: rd_val = t0cnt_r;
      `EPT_IDX_T1CNT: rd_val = t1cnt_r;
      `EPT_IDX_IRQ:   rd_val = {1'b0, irq_r};
      default: begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= 18'h00000;
      w_hold_r  <= 1'b0;
      w_data_r  <= 32'h00000000;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= 2'b00;
      rvalid_r  <= 1'b0;
      rresp_r   <= 2'b00;
      rdata_r   <= 32'h00000000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end

      // The write lands at the same edge that raises bvalid.
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_hit ? `EPT_RESP_OKAY : `EPT_RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end

      // The read is answered from the address as it stands when arvalid is sampled.
      if (s_axi_arvalid && !rvalid_r) begin
        rvalid_r <= 1'b1;
        rdata_r  <= {24'h000000, rd_val};
        rresp_r  <= rd_hit ? `EPT_RESP_OKAY : `EPT_RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

endmodule // ept_timer
`default_nettype wire

// *** core/ept_map.vh ***
// Register offsets, field positions, reset values and timing counts of the event/pulse timer.
`ifndef EPT_MAP_VH
`define EPT_MAP_VH
`define EPT_IDX_MODE      16'hFF30
`define EPT_IDX_T0CTL     16'hFF31
`define EPT_IDX_T1CTL     16'hFF32
`define EPT_IDX_T0RLD     16'hFF33
`define EPT_IDX_T1RLD     16'hFF34
`define EPT_IDX_T0CNT     16'hFF35
`define EPT_IDX_T1CNT     16'hFF36
`define EPT_IDX_IRQ       16'hFF37
`define EPT_AW            18
`define EPT_MODE_CASCADE  4
`define EPT_MODE_OUTSEL   3
`define EPT_MODE_OUTEN    2
`define EPT_MODE_CK1      1
`define EPT_MODE_CK0      0
`define EPT_C_CNTMODE     7
`define EPT_C_FUNC        6
`define EPT_C_POL         5
`define EPT_C_PSC_HI      4
`define EPT_C_PSC_LO      3
`define EPT_C_CONT        2
`define EPT_C_PSET        1
`define EPT_C_PRUN        0
`define EPT_I_F0          0
`define EPT_I_F1          1
`define EPT_I_E0          2
`define EPT_I_E1          3
`define EPT_I_PRIO_LO     4
`define EPT_I_PRIO_HI     5
`define EPT_I_LATCH       6
`define EPT_RLD_RESET     8'hFF
`define EPT_VEC_T1        24'h000006
`define EPT_VEC_T0        24'h000008
`define EPT_CLK_HZ        50000000
`define EPT_NR_HZ         2048
`define EPT_NR_HALF       ((`EPT_CLK_HZ / `EPT_NR_HZ) / 2)
`define EPT_RESP_OKAY     2'b00
`define EPT_RESP_SLVERR   2'b10
`endif

// *** test/ept_props.sv ***
// Port-level assertion checker for the event/pulse timer.
`timescale 1ns/1ns
`default_nettype none
module ept_props (
  input wire logic        aclk,                   // Clock.
  input wire logic        aresetn,                // Reset, active low.
  input wire logic        s_axi_awvalid,          // Write address valid.
  input wire logic        s_axi_awready,          // Write address ready.
  input wire logic        s_axi_wvalid,           // Write data valid.
  input wire logic        s_axi_wready,           // Write data ready.
  input wire logic [1:0]  s_axi_bresp,            // Write response.
  input wire logic        s_axi_bvalid,           // Write response valid.
  input wire logic        s_axi_bready,           // Write response ready.
  input wire logic        s_axi_arvalid,          // Read address valid.
  input wire logic        s_axi_arready,          // Read address ready.
  input wire logic [31:0] s_axi_rdata,            // Read data.
  input wire logic        s_axi_rvalid,           // Read data valid.
  input wire logic        s_axi_rready,           // Read data ready.
  input wire logic [23:0] t0_irq_vector,          // Timer 0 vector.
  input wire logic [23:0] t1_irq_vector,          // Timer 1 vector.
  input wire logic        serial_clock_tick,      // Timer 1 underflow.
  input wire logic        pulse_out_pin,          // Pulse output.
  input wire logic        inverted_pulse_out_pin  // Inverted pulse output.
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_wr_resp; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response missing");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_b_once; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_once: assert property (p_b_once) else $error("write response repeated");
  property p_rd_resp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read response missing");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  property p_ar_refuse; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_refuse: assert property (p_ar_refuse) else $error("read taken while answer pending");
  property p_vectors; t0_irq_vector == 24'h000008 && t1_irq_vector == 24'h000006; endproperty
  a_vectors: assert property (p_vectors) else $error("wrong exception vector");
  // Enabled, latched or off, the inverted pin is never high together with the true pin.
  property p_out_pair; inverted_pulse_out_pin |-> !pulse_out_pin; endproperty
  a_out_pair: assert property (p_out_pair) else $error("pulse output pair inconsistent");
  property p_tick_pulse; serial_clock_tick |=> !serial_clock_tick; endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("serial tick longer than one cycle");
  c_tick: cover property (serial_clock_tick);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
  c_pinv: cover property ($rose(inverted_pulse_out_pin));
endmodule // ept_props
bind ept_timer ept_props u_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .t0_irq_vector(t0_irq_vector), .t1_irq_vector(t1_irq_vector),
  .serial_clock_tick(serial_clock_tick), .pulse_out_pin(pulse_out_pin),
  .inverted_pulse_out_pin(inverted_pulse_out_pin)
);
`default_nettype wire

// *** test/ept_event_src.sv ***
// Behavioural external event source driving the event input pin.
`timescale 1ns/1ns
`default_nettype none
module ept_event_src #(
  parameter int MIN_HOLD = 4
) (
  input  wire logic aclk,            // Clock the source is aligned to.
  output var  logic event_input_pin  // Event or pulse level.
);
  initial event_input_pin = 1'b1;
  task automatic level(input logic v, input int hold);
    begin
      @(posedge aclk);
      event_input_pin <= v;
      repeat ((hold < MIN_HOLD) ? MIN_HOLD : hold) @(posedge aclk);
    end
  endtask
  // A spike far shorter than the rejector window, sent only on request.
  task automatic glitch(input int width);
    begin
      @(posedge aclk);
      event_input_pin <= ~event_input_pin;
      repeat (width) @(posedge aclk);
      event_input_pin <= ~event_input_pin;
    end
  endtask
endmodule // ept_event_src
`default_nettype wire

// *** test/testbench.sv ***
// Self-checking testbench for the event/pulse timer.
`timescale 1ns/1ns
`default_nettype none
`include "ept_map.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; $display("MISMATCH %0t %h %h", $time, g, e); end end
module testbench;
  logic        aclk, aresetn, slow_osc, fast_osc, awvalid, wvalid, bready, arvalid, rready, ev_pin;
  logic        awready, wready, bvalid, arready, rvalid, t0_irq, t1_irq, tick, rl_mode, pout, pinv;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, prio;
  logic [23:0] v0, v1;
  logic [3:0]  div;
  int          n_errors, cmp_count;
  ept_timer DUT (
    .aclk(aclk), .aresetn(aresetn), .slow_oscillator(slow_osc), .fast_oscillator(fast_osc),
    .event_input_pin(ev_pin), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .t0_irq(t0_irq), .t1_irq(t1_irq),
    .timer_irq_priority(prio), .t0_irq_vector(v0), .t1_irq_vector(v1), .serial_clock_tick(tick),
    .t1_reload_count_mode(rl_mode), .pulse_out_pin(pout), .inverted_pulse_out_pin(pinv));
  ept_event_src #(.MIN_HOLD(4)) u_src (.aclk(aclk), .event_input_pin(ev_pin));
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // Source clocks are sampled by the block, so they must stay well below half of aclk.
  always @(posedge aclk) begin
    div <= div + 4'h1;
    fast_osc <= div[1];
    slow_osc <= div[3];
  end
  task automatic results;
    begin
      if (n_errors == 0 && cmp_count > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] d, output logic [1:0] r);
    begin
      awaddr <= {idx, 2'b00};
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
        @(posedge aclk);
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
        if (bvalid) begin
          r = bresp;
          bready <= 1'b0;
          break;
        end
      end
      @(posedge aclk);
    end
  endtask
  task automatic rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
    begin
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
        @(posedge aclk);
        if (arvalid && arready) arvalid <= 1'b0;
        if (rvalid) begin
          d = rdata;
          r = rresp;
          rready <= 1'b0;
          break;
        end
      end
      @(posedge aclk);
    end
  endtask
  task automatic w(input logic [15:0] idx, input logic [7:0] d);
    logic [1:0] r;
    begin
      wr(idx, d, r);
      `CHK(r, 2'b00)
    end
  endtask
  task automatic rc(input logic [15:0] idx, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    begin
      rd(idx, d, r);
      `CHK({r, d}, {2'b00, e})
    end
  endtask
  task automatic ev(input logic v, input logic [7:0] e);
    begin
      u_src.level(v, 8);
      rc(`EPT_IDX_T0CNT, {24'h000000, e});
    end
  endtask
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    begin
      rc(`EPT_IDX_MODE, 32'h00000000);
      `CHK({pout, pinv}, 2'b10)
      w(`EPT_IDX_MODE, 8'hFF);
      rc(`EPT_IDX_MODE, 32'h0000001F);
      w(`EPT_IDX_MODE, 8'h00);
      rd(16'hFF38, d, r);
      `CHK({r, d}, {2'b10, 32'h00000000})
      wr(16'hFF38, 8'h55, r);
      `CHK(r, 2'b10)
    end
  endtask
  task automatic t_event;
    begin
      w(`EPT_IDX_T0RLD, 8'h10);
      w(`EPT_IDX_T0CTL, 8'h9E);
      w(`EPT_IDX_T0CTL, 8'h9D);
      ev(1'b0, 8'h0F);
      ev(1'b1, 8'h0F);
      ev(1'b0, 8'h0E);
      w(`EPT_IDX_T0CTL, 8'hBD);
      ev(1'b1, 8'h0D);
      ev(1'b0, 8'h0D);
      w(`EPT_IDX_T0CTL, 8'hDD);
      u_src.glitch(5);
      repeat (100) @(posedge aclk);
      rc(`EPT_IDX_T0CNT, 32'h0000000D);
      // The held low level is seen at one reference fall and accepted only at the next.
      repeat (23000) @(posedge aclk);
      rc(`EPT_IDX_T0CNT, 32'h0000000D);
      repeat (14000) @(posedge aclk);
      rc(`EPT_IDX_T0CNT, 32'h0000000C);
      w(`EPT_IDX_T0CTL, 8'h00);
    end
  endtask
  task automatic t_pulse;
    logic [31:0] d;
    logic [1:0]  r;
    begin
      w(`EPT_IDX_MODE, 8'h01);
      w(`EPT_IDX_T0RLD, 8'hFF);
      w(`EPT_IDX_T0CTL, 8'h66);
      w(`EPT_IDX_T0CTL, 8'h65);
      repeat (100) @(posedge aclk);
      rc(`EPT_IDX_T0CNT, 32'h000000FF);
      u_src.level(1'b1, 160);
      u_src.level(1'b0, 20);
      rd(`EPT_IDX_T0CNT, d, r);
      `CHK((d[7:0] inside {[8'hD5:8'hD8]}), 1'b1)
      w(`EPT_IDX_T0CTL, 8'h25);
      repeat (100) @(posedge aclk);
      rd(`EPT_IDX_T0CNT, d, r);
      `CHK((d[7:0] inside {[8'hB8:8'hC2]}), 1'b1)
      w(`EPT_IDX_T0CTL, 8'h00);
    end
  endtask
  task automatic t_out;
    int   a, b;
    logic last;
    begin
      a = 0;
      b = 0;
      w(`EPT_IDX_T1RLD, 8'h00);
      w(`EPT_IDX_MODE, 8'h0E);
      w(`EPT_IDX_IRQ, 8'h4B);
      w(`EPT_IDX_T1CTL, 8'h06);
      w(`EPT_IDX_T1CTL, 8'h05);
      last = pout;
      repeat (200) begin
        @(posedge aclk);
        a += tick;
        b += (pout != last);
        last = pout;
      end
      `CHK((a inside {[48:51]}), 1'b1)
      `CHK(((b - a) inside {[-1:1]}), 1'b1)
      `CHK({t1_irq, t0_irq}, 2'b10)
      w(`EPT_IDX_IRQ, 8'h08);
      a = 0;
      b = 0;
      last = pinv;
      repeat (40) begin
        @(posedge aclk);
        a += pout;
        b += (pinv != last);
        last = pinv;
      end
      `CHK({(a == 0), (b > 5)}, 2'b11)
      w(`EPT_IDX_MODE, 8'h0A);
      `CHK({pout, pinv}, 2'b10)
      for (int p = 0; p < 4; p++) begin
        w(`EPT_IDX_IRQ, {2'b00, p[1:0], 4'b1000});
        `CHK(prio, p[1:0])
      end
      w(`EPT_IDX_T1CTL, 8'h00);
      w(`EPT_IDX_T0RLD, 8'h00);
      w(`EPT_IDX_MODE, 8'h11);
      w(`EPT_IDX_T0CTL, 8'h06);
      w(`EPT_IDX_T0CTL, 8'h05);
      w(`EPT_IDX_IRQ, 8'h4F);
      repeat (50) @(posedge aclk);
      rc(`EPT_IDX_IRQ, 32'h0000004E);
      `CHK(t0_irq, 1'b0)
    end
  endtask
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, div} = '0;
    {awaddr, araddr, wdata, n_errors, cmp_count} = '0;
    {slow_osc, fast_osc} = 2'b00;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_event;
    t_pulse;
    t_out;
    results;
  end
  initial begin
    repeat (60000) @(posedge aclk);
    n_errors++;
    results;
  end
endmodule // testbench
`default_nettype wire
